/* File: nac_ctrl.sv */
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "nac_defines.svh"
module nac_ctrl
   import nac_pkg::*;
#(
   parameter int unsigned PROG_CYCLES =
      `NAC_PROG_TIME_US * `NAC_CLK_MHZ
) (
   input  wire logic          I_CLK_SYS,
   input  wire logic          I_RST_N,
   input  wire logic          I_PSEL,
   input  wire logic          I_PENABLE,
   input  wire logic          I_PWRITE,
   input  wire logic [11:0]   I_PADDR,
   input  wire logic [31:0]   I_PWDATA,
   input  wire logic          I_WARM_RST_REQ,
   output logic      [31:0]   O_PRDATA,
   output logic               O_PREADY,
   output logic               O_PSLVERR,
   output nac_pkg::nac_op_t   O_NVM_OP,
   output logic               O_NVM_FETCH,
   output logic               O_IRQ
);
   import nac_pkg::*;

   nac_ctrl_t            ctrl_q;
   nac_state_t           state_q;
   logic [21:0]          table_ptr_q;
   logic [`NAC_IRQ_W-1:0] mask_q;
   logic [`NAC_IRQ_W-1:0] irq_status;
   logic [`NAC_IRQ_W-1:0] irq_event;
   logic                 prog_done;
   logic                 start_prog;
   logic                 start_fetch;
   logic                 blocked;
   logic                 acc;
   logic                 wr;
   logic                 rd;
   logic                 irq_rd_clr;
   logic                 warm_q;
   logic [7:0]           wb;
   logic                 wr_ctrl;
   logic                 idle;
   logic                 setup;
   logic                 prog_fin;
   logic                 blocked_q;
   logic                 irq_clr_ok;
   logic [`NAC_IRQ_W-1:0] irq_seen_q;
   logic [21:0]          row_addr;
   logic [31:0]          rdata_d;
   logic                 slverr_d;

   initial begin
      if (PROG_CYCLES < 1) $error("nac_ctrl: PROG_CYCLES below one");
   end

   assign acc     = I_PSEL && I_PENABLE;
   assign setup   = I_PSEL && !I_PENABLE;
   assign wr      = acc && I_PWRITE;
   assign rd      = acc && !I_PWRITE;
   assign wb      = I_PWDATA[7:0];
   assign wr_ctrl = wr && (I_PADDR == `NAC_ADDR_CTRL);
   assign idle    = (state_q == NAC_IDLE);

   // Row erase drops the in-row offset bits
   assign row_addr = {table_ptr_q[21:`NAC_ROW_LSB], `NAC_ROW_LSB'(0)};

   // Read data were taken at the setup edge; an event that lands between
   // that edge and the access edge would be wiped unseen. The clear then
   // waits for the next read: a bit reported twice beats a bit lost.
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         irq_seen_q <= '0;
      end else if (setup) begin
         irq_seen_q <= irq_status;
      end
   end

   assign irq_clr_ok = (irq_status == irq_seen_q);
   assign irq_rd_clr = rd && (I_PADDR == `NAC_ADDR_IRQ_STAT) && irq_clr_ok;

   // Writes to the trigger bits only matter while idle; a warm reset
   // in progress refuses them, else sequencer and register disagree
   always_comb begin
      start_prog  = 1'b0;
      start_fetch = 1'b0;
      blocked     = 1'b0;
      if (wr_ctrl && idle && !warm_q) begin
         if (wb[`NAC_BIT_PROG]) begin
            if (wb[`NAC_BIT_PERMIT] || ctrl_q.cycle_permit) begin
               start_prog = 1'b1;
            end else begin
               blocked = 1'b1;
            end
         end else if (wb[`NAC_BIT_FETCH] && !wb[`NAC_BIT_MEMSEL]) begin
            start_fetch = 1'b1;
         end
      end
   end

   nac_timer #(
      .CYCLES (PROG_CYCLES)
   ) u_timer (
      .i_clk   (I_CLK_SYS),
      .i_rst_n (I_RST_N),
      .i_start (start_prog),
      .o_done  (prog_done)
   );

   // A cycle cut by a warm reset leaves the timer running; its late done
   // pulse must not be reported as a finished cycle
   assign prog_fin  = prog_done && (state_q == NAC_PROG) && !warm_q;
   assign irq_event = {blocked, start_fetch, prog_fin};

   nac_irq #(
      .N (`NAC_IRQ_W)
   ) u_irq (
      .i_clk    (I_CLK_SYS),
      .i_rst_n  (I_RST_N),
      .i_event  (irq_event),
      .i_clear  (irq_rd_clr),
      .i_mask   (mask_q),
      .o_status (irq_status),
      .o_irq    (O_IRQ)
   );

   // Blocked stays up until the next accepted program trigger, so software can
   // still see why nothing ran long after the refused write
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         blocked_q <= 1'b0;
      end else if (blocked) begin
         blocked_q <= 1'b1;
      end else if (start_prog) begin
         blocked_q <= 1'b0;
      end
   end

   // Sequencer
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_q <= NAC_IDLE;
      end else begin
         case (state_q)
            NAC_IDLE: begin
               if (start_prog) begin
                  state_q <= NAC_PROG;
               end else if (start_fetch) begin
                  state_q <= NAC_FETCH;
               end
            end
            NAC_PROG: begin
               if (warm_q || prog_done) begin
                  state_q <= NAC_IDLE;
               end
            end
            NAC_FETCH: state_q <= NAC_IDLE;
            default:   state_q <= NAC_IDLE;
         endcase
      end
   end

   // Warm reset from the system; the abort flag must survive it
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         warm_q <= 1'b0;
      end else begin
         warm_q <= I_WARM_RST_REQ;
      end
   end

   // Control register
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         ctrl_q <= nac_ctrl_t'(`NAC_CTRL_RESET);
      end else if (warm_q) begin
         // Space selects are kept for tracing
         ctrl_q.row_erase     <= 1'b0;
         ctrl_q.cycle_permit  <= 1'b0;
         ctrl_q.prog_trigger  <= 1'b0;
         ctrl_q.fetch_trigger <= 1'b0;
         if (state_q == NAC_PROG) begin
            ctrl_q.abort_flag <= 1'b1;
         end
      end else begin
         if (wr && I_PADDR == `NAC_ADDR_CTRL) begin
            if (state_q == NAC_IDLE) begin
               ctrl_q.memory_space_select <= wb[`NAC_BIT_MEMSEL];
               ctrl_q.config_space_select <= wb[`NAC_BIT_CFGSEL];
               ctrl_q.row_erase  <= wb[`NAC_BIT_ROWERASE];
            end
            ctrl_q.abort_flag   <= wb[`NAC_BIT_ABORT];
            ctrl_q.cycle_permit <= wb[`NAC_BIT_PERMIT];
         end
         ctrl_q.unused <= 1'b0;
         if (start_prog) begin
            ctrl_q.prog_trigger <= 1'b1;
         end else if (prog_done && state_q == NAC_PROG) begin
            ctrl_q.prog_trigger <= 1'b0;
            ctrl_q.abort_flag   <= 1'b0;
            if (ctrl_q.row_erase) begin
               ctrl_q.row_erase <= 1'b0;
            end
         end
         if (start_fetch) begin
            ctrl_q.fetch_trigger <= 1'b1;
         end else if (state_q == NAC_FETCH) begin
            ctrl_q.fetch_trigger <= 1'b0;
         end
      end
   end

   // Table pointer and mask
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         table_ptr_q <= '0;
         mask_q      <= '0;
      end else if (wr) begin
         if (I_PADDR == `NAC_ADDR_TABLE_PTR && idle) begin
            table_ptr_q <= I_PWDATA[21:0];
         end
         if (I_PADDR == `NAC_ADDR_IRQ_MASK) begin
            mask_q <= I_PWDATA[`NAC_IRQ_W-1:0];
         end
      end
   end

   // Request to the arrays
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_NVM_OP    <= '0;
         O_NVM_FETCH <= 1'b0;
      end else begin
         O_NVM_OP.start <= start_prog;
         O_NVM_FETCH    <= start_fetch;
         if (start_prog) begin
            O_NVM_OP.erase <= wb[`NAC_BIT_ROWERASE];
            O_NVM_OP.memory_space_select <= wb[`NAC_BIT_MEMSEL];
            O_NVM_OP.config_space_select <= wb[`NAC_BIT_CFGSEL];
            O_NVM_OP.addr <= wb[`NAC_BIT_ROWERASE] ? row_addr
               : table_ptr_q;
         end else if (start_fetch) begin
            O_NVM_OP.erase <= 1'b0;
            O_NVM_OP.memory_space_select <= 1'b0;
            O_NVM_OP.config_space_select <= wb[`NAC_BIT_CFGSEL];
            O_NVM_OP.addr <= table_ptr_q;
         end
      end
   end

   // Register read mux, looked at only in the setup cycle
   always_comb begin
      rdata_d  = '0;
      slverr_d = 1'b0;
      case (I_PADDR)
         `NAC_ADDR_CTRL: begin
            rdata_d = {24'h000000, ctrl_q};
         end
         `NAC_ADDR_STATUS: begin
            rdata_d = {29'h00000000, blocked_q,
               ctrl_q.row_erase && state_q == NAC_PROG, !idle};
         end
         `NAC_ADDR_IRQ_STAT: begin
            rdata_d = {29'h00000000, irq_status};
         end
         `NAC_ADDR_IRQ_MASK: begin
            rdata_d = {29'h00000000, mask_q};
         end
         `NAC_ADDR_TABLE_PTR: begin
            rdata_d = {10'h000, table_ptr_q};
         end
         default: begin
            slverr_d = 1'b1;
         end
      endcase
   end

   // APB answer: ready one cycle after setup, so never a wait state
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA  <= '0;
         O_PREADY  <= 1'b0;
         O_PSLVERR <= 1'b0;
      end else begin
         O_PREADY  <= setup;
         O_PSLVERR <= setup && slverr_d;
         O_PRDATA  <= setup ? rdata_d : '0;
      end
   end
endmodule : nac_ctrl

/* File: nac_defines.svh */
`ifndef NAC_DEFINES_SVH
`define NAC_DEFINES_SVH

// Register byte addresses
`define NAC_ADDR_CTRL      12'h000
`define NAC_ADDR_STATUS    12'h004
`define NAC_ADDR_IRQ_STAT  12'h008
`define NAC_ADDR_IRQ_MASK  12'h00C
`define NAC_ADDR_TABLE_PTR 12'h010

// Control register fields
`define NAC_BIT_MEMSEL     7
`define NAC_BIT_CFGSEL     6
`define NAC_BIT_UNUSED     5
`define NAC_BIT_ROWERASE   4
`define NAC_BIT_ABORT      3
`define NAC_BIT_PERMIT     2
`define NAC_BIT_PROG       1
`define NAC_BIT_FETCH      0

// Status register fields
`define NAC_ST_BUSY        0
`define NAC_ST_ERASING     1
`define NAC_ST_BLOCKED     2

// Interrupt status fields
`define NAC_IRQ_PROG_DONE  0
`define NAC_IRQ_FETCH_DONE 1
`define NAC_IRQ_BLOCKED    2
`define NAC_IRQ_W          3

`define NAC_ROW_LSB        6
`define NAC_CTRL_RESET     8'h00
`define NAC_PROG_TIME_US   2000
`define NAC_CLK_MHZ        25

`endif

/* File: nac_pkg.sv */
package nac_pkg;
   typedef struct packed {
      logic memory_space_select;
      logic config_space_select;
      logic unused;
      logic row_erase;
      logic abort_flag;
      logic cycle_permit;
      logic prog_trigger;
      logic fetch_trigger;
   } nac_ctrl_t;

   typedef struct packed {
      logic        start;
      logic        erase;
      logic        memory_space_select;
      logic        config_space_select;
      logic [21:0] addr;
   } nac_op_t;

   typedef enum logic [2:0] {
      NAC_IDLE  = 3'b001,
      NAC_PROG  = 3'b010,
      NAC_FETCH = 3'b100
   } nac_state_t;
endpackage : nac_pkg

/* File: nac_timer.sv */
`timescale 1ns/1ps
`include "nac_defines.svh"
module nac_timer #(
   parameter int unsigned CYCLES = 50000
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_start,
   output logic      o_done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q;
   logic         run_q;

   initial begin
      if (CYCLES < 1) $error("nac_timer: CYCLES must be at least 1");
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_q <= W'(CYCLES - 1);
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q == '0) begin
               run_q  <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule : nac_timer

/* File: nac_irq.sv */
`timescale 1ns/1ps
`include "nac_defines.svh"
module nac_irq #(
   parameter int N = `NAC_IRQ_W
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [N-1:0] i_event,
   input  wire logic         i_clear,
   input  wire logic [N-1:0] i_mask,
   output logic      [N-1:0] o_status,
   output logic              o_irq
);
   initial begin
      if (N < 1) $error("nac_irq: N must be positive");
   end

   // Set beats the read-clear in the same cycle
   for (genvar g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            o_status[g] <= 1'b0;
         end else if (i_event[g]) begin
            o_status[g] <= 1'b1;
         end else if (i_clear) begin
            o_status[g] <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(o_status & i_mask);
      end
   end
endmodule : nac_irq

/* File: nac_ctrl_sva.sv */
`timescale 1ns/1ps
module nac_ctrl_sva
   import nac_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = 8
) (
   input wire logic             I_CLK_SYS,
   input wire logic             I_RST_N,
   input wire logic             I_PSEL,
   input wire logic             I_PENABLE,
   input wire logic             I_PWRITE,
   input wire logic [11:0]      I_PADDR,
   input wire logic [31:0]      I_PWDATA,
   input wire logic             I_WARM_RST_REQ,
   input wire logic [31:0]      O_PRDATA,
   input wire logic             O_PREADY,
   input wire logic             O_PSLVERR,
   input wire nac_pkg::nac_op_t O_NVM_OP,
   input wire logic             O_NVM_FETCH,
   input wire logic             O_IRQ
);
   logic wr_ctrl;
   logic wr_prog;
   logic wr_fetch;
   assign wr_ctrl  = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 12'h000;
   assign wr_prog  = wr_ctrl && I_PWDATA[1];
   assign wr_fetch = wr_ctrl && I_PWDATA[0] && !I_PWDATA[7];
   default clocking @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);
   sequence setup_s;
      I_PSEL && !I_PENABLE;
   endsequence
   sequence quiet_s;
      !O_NVM_OP.start [*2];
   endsequence
   ready_turn_a: assert property (setup_s |=> O_PREADY)
      else $error("no ready after setup");
   ready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (O_PSLVERR |-> O_PREADY)
      else $error("slverr without ready");
   start_pulse_a: assert property (O_NVM_OP.start |=> quiet_s)
      else $error("start pulse too long");
   row_align_a: assert property (O_NVM_OP.start && O_NVM_OP.erase
      |-> O_NVM_OP.addr[5:0] == 6'h00) else $error("row address not aligned");
   fetch_pulse_a: assert property (O_NVM_FETCH |=> !O_NVM_FETCH)
      else $error("fetch pulse too long");
   start_cause_a: assert property (O_NVM_OP.start
      |-> $past(wr_prog) || $past(wr_prog, 2)) else $error("start uncaused");
   fetch_cause_a: assert property (O_NVM_FETCH
      |-> $past(wr_fetch) || $past(wr_fetch, 2)) else $error("fetch uncaused");
endmodule : nac_ctrl_sva

/* File: nac_nvm_model.sv */
`timescale 1ns/1ps
module nac_nvm_model
   import nac_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire nac_pkg::nac_op_t i_op,
   input  wire logic             i_fetch,
   output int                    o_n_start,
   output int                    o_n_fetch,
   output nac_pkg::nac_op_t      o_last
);
   // Array only records cycles; it has no return path to the block
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_n_start <= 0;
         o_n_fetch <= 0;
         o_last    <= '0;
      end else begin
         if (i_op.start) begin
            o_n_start <= o_n_start + 1;
            o_last    <= i_op;
         end
         if (i_fetch) begin
            o_n_fetch <= o_n_fetch + 1;
         end
      end
   end
endmodule : nac_nvm_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
   import nac_pkg::*;
   localparam int unsigned PROG_CYCLES = 8;
   logic        clk, rst_n, psel, pen, pwr, warm, pready, pslverr, irq, fetch;
   logic        err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   nac_op_t     op, last;
   int          failures, n_checks, n_st, n_fe;
   int          cyc = 0;
   nac_ctrl #(.PROG_CYCLES(PROG_CYCLES)) dut_u (.I_CLK_SYS(clk),
      .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .I_WARM_RST_REQ(warm),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_NVM_OP(op), .O_NVM_FETCH(fetch), .O_IRQ(irq));
   nac_nvm_model nvm_u (.i_clk(clk), .i_rst_n(rst_n), .i_op(op),
      .i_fetch(fetch), .o_n_start(n_st), .o_n_fetch(n_fe), .o_last(last));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Only the bench timeout ends a wait that never sees ready
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic wait_idle;
      do begin
         apb(1'b0, 12'h000, 32'h0);
      end while (rd[1] !== 1'b0);
   endtask : wait_idle
   task automatic t_reg;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h000, 32'h20);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 12'h020, 32'h1);
      chk(err, 1'b1);
   endtask : t_reg
   task automatic t_block;
      apb(1'b1, 12'h000, 32'h02);
      repeat (3) @(posedge clk);
      chk(n_st, 0);
      chk(irq, 1'b0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h4);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[2], 1'b1);
   endtask : t_block
   task automatic t_prog;
      apb(1'b1, 12'h00C, 32'h1);
      apb(1'b1, 12'h010, 32'h12345);
      apb(1'b1, 12'h000, 32'h84);
      apb(1'b1, 12'h000, 32'h86);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[1], 1'b1);
      wait_idle();
      chk(rd, 32'h84);
      chk({last.memory_space_select, last.erase}, 2'b10);
      chk(last.addr, 22'h12345);
      chk(irq, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[0], 1'b1);
      repeat (3) @(posedge clk);
      chk(irq, 1'b0);
   endtask : t_prog
   task automatic t_erase;
      apb(1'b1, 12'h010, 32'h1FF);
      apb(1'b1, 12'h000, 32'h94);
      apb(1'b1, 12'h000, 32'h96);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h3);
      wait_idle();
      chk(rd, 32'h84);
      chk({last.erase, last.addr}, {1'b1, 22'h1C0});
   endtask : t_erase
   task automatic t_abort;
      apb(1'b1, 12'h000, 32'hC4);
      apb(1'b1, 12'h000, 32'hC6);
      warm <= 1'b1;
      repeat (2) @(posedge clk);
      warm <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'hC8);
      chk(last.config_space_select, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      repeat (12) @(posedge clk);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[0], 1'b0);
   endtask : t_abort
   task automatic t_fetch;
      apb(1'b1, 12'h000, 32'h01);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[0], 1'b0);
      chk(n_fe, 1);
      apb(1'b1, 12'h000, 32'h81);
      apb(1'b0, 12'h000, 32'h0);
      chk(n_fe, 1);
   endtask : t_fetch
   task automatic test_done;
      $display("failures=%0d n_checks=%0d", failures, n_checks);
      if (failures == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : test_done
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      {rst_n, psel, pen, pwr, warm} = '0;
      paddr    = '0;
      pwdata   = '0;
      failures = 0;
      n_checks = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reg();
      t_block();
      t_prog();
      t_erase();
      t_abort();
      t_fetch();
      test_done();
   end
endmodule : tb
bind nac_ctrl nac_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES)) sva_u (
   .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA), .I_WARM_RST_REQ(I_WARM_RST_REQ),
   .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
   .O_NVM_OP(O_NVM_OP), .O_NVM_FETCH(O_NVM_FETCH), .O_IRQ(O_IRQ));
